// *** rtl/adc14_pkg.sv ***
// Purpose: constants for the 14-bit converter trigger and byte readout block
// Assumes: 100 MHz reference clock, 10 ns period
// Notes: times are in ns; cycle counts are derived from them
package adc14_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;        // Reference clock period
    localparam int TRIG_HIGH_MIN_NS = 100;    // Least trigger high time
    localparam int TRIG_LOW_MIN_NS = 200;     // Least trigger low time
    localparam int EOC_RISE_NS = 100;         // Trigger fall to flag rise
    localparam int LOAD_LEAD_NS = 300;        // Latch load before flag fall
    localparam int STROBE_LEAD_NS = 100;      // Strobe fall before load
    localparam int CONV_MAX_NS = 7000;        // Longest conversion

    // Least times round up, longest times round down
    localparam int TRIG_LOW_MIN_CYC =
        (TRIG_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EOC_RISE_CYC = EOC_RISE_NS / CLK_PERIOD_NS;
    localparam int LOAD_LEAD_CYC = LOAD_LEAD_NS / CLK_PERIOD_NS;
    localparam int STROBE_LEAD_CYC = STROBE_LEAD_NS / CLK_PERIOD_NS;
    localparam int CONV_MAX_CYC = CONV_MAX_NS / CLK_PERIOD_NS;
    // Cycles spent on the bit trials, leaving room for the tail
    localparam int BIT_PHASE_CYC = CONV_MAX_CYC - EOC_RISE_CYC
        - STROBE_LEAD_CYC - LOAD_LEAD_CYC - 10;

    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int RESULT_W = 14;             // Result width
    localparam int FIFO_DEPTH = 16;           // Sample FIFO depth
    localparam int CNT_W = 10;                // Phase counter width
    localparam logic [13:0] RESULT_RST = 14'h0000;

    // Sequencer states
    typedef enum logic [5:0] {
        ST_IDLE   = 6'b00_0001,
        ST_RISE   = 6'b00_0010,
        ST_TRIAL  = 6'b00_0100,
        ST_STROBE = 6'b00_1000,
        ST_HOLD   = 6'b01_0000,
        ST_WAITLO = 6'b10_0000
    } conv_state_t;

endpackage : adc14_pkg

// *** rtl/sample_fifo.sv ***
// Purpose: small synchronous FIFO carrying finished samples
// Assumes: one clock, clock enable freezes all state
// Notes: valid/ready on both sides; full and empty are exact
`timescale 1ns/1ps
module sample_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 16
) (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];     // Storage
    logic [AW-1:0] wr_ptr_r;             // Write pointer
    logic [AW-1:0] rd_ptr_r;             // Read pointer
    logic [AW:0] count_r;                // Words held
    logic push;
    logic pop;

    assign o_in_ready = (count_r != DEPTH[AW:0]);
    assign o_out_valid = (count_r != '0);
    assign o_out_data = mem_r[rd_ptr_r];
    assign push = i_ce & i_in_valid & o_in_ready;
    assign pop = i_ce & o_out_valid & i_out_ready;

    // ------------------------------------------------------------------
    // Pointer wrap
    // ------------------------------------------------------------------
    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : ptr_inc

    // Storage write
    always_ff @(posedge i_ref_clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= i_in_data;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= ptr_inc(wr_ptr_r);
            end
            if (pop) begin
                rd_ptr_r <= ptr_inc(rd_ptr_r);
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end

endmodule : sample_fifo

// *** rtl/sar_core.sv ***
// Purpose: successive approximation register for the digital side
// Assumes: comparator input is synchronous and settles each step
// Notes: one trial per step pulse, MSB first
`timescale 1ns/1ps
module sar_core #(
    parameter int WIDTH = 14
) (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic i_start,
    input wire logic i_step,
    input wire logic i_comp_hi,
    output logic [WIDTH-1:0] o_trial,
    output logic o_done
);
    logic [WIDTH-1:0] trial_r;           // Current trial code
    logic [WIDTH-1:0] mask_r;            // Bit under test

    assign o_trial = trial_r;
    assign o_done = (mask_r == '0);

    // Trial and mask update
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            trial_r <= '0;
            mask_r <= '0;
        end else if (i_ce) begin
            if (i_start) begin
                // Begin with the MSB set
                mask_r <= {1'b1, {(WIDTH-1){1'b0}}};
                trial_r <= {1'b1, {(WIDTH-1){1'b0}}};
            end else if (i_step && mask_r != '0) begin
                // Keep or drop the bit, then try the next lower one
                trial_r <= (i_comp_hi ? trial_r : (trial_r & ~mask_r))
                    | (mask_r >> 1);
                mask_r <= mask_r >> 1;
            end
        end
    end

endmodule : sar_core

// *** rtl/adc14_readout.sv ***
// Purpose: trigger, end-of-conversion, update strobe and byte readout
// Assumes: pins synchronous to i_ref_clk; comparator from analog side
// Notes: data pins are split into value and drive enable signals
`timescale 1ns/1ps
module adc14_readout #(
    parameter int WIDTH = adc14_pkg::RESULT_W,
    parameter int DEPTH = adc14_pkg::FIFO_DEPTH
) (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic i_trigger,
    input wire logic i_high_en_n,
    input wire logic i_low_en_n,
    input wire logic i_comp_hi,
    output logic o_eoc,
    output logic o_data_update_strobe,
    output logic o_result_msb_n,
    output logic o_result_msb_true,
    output logic [4:0] o_high_bits,
    output logic [7:0] o_low_bits,
    output logic o_high_oe,
    output logic o_low_oe,
    output logic o_trig_short,
    output logic [WIDTH-1:0] o_sample,
    output logic o_sample_valid,
    input wire logic i_sample_ready
);
    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    adc14_pkg::conv_state_t state_r;     // Sequencer state
    adc14_pkg::conv_state_t state_nxt;   // Next state
    logic [adc14_pkg::CNT_W-1:0] cnt_r;  // Phase counter
    logic [adc14_pkg::CNT_W-1:0] low_cnt_r; // Trigger low time
    logic trig_d_r;                      // Trigger, one cycle back
    logic trig_fall;                     // Trigger falling edge
    logic [WIDTH-1:0] latch_r;           // Output latches
    logic eoc_r;                         // End-of-conversion flag
    logic strobe_r;                      // Data update strobe
    logic high_oe_r;                     // High byte drive
    logic low_oe_r;                      // Low byte drive
    logic short_r;                       // Trigger low too short
    logic msb_n_r; // Inverted MSB
    logic latch_load; // Latch update
    logic sar_start;
    logic sar_step;
    logic sar_done;
    logic [WIDTH-1:0] sar_trial;
    logic [WIDTH-1:0] fifo_out;
    logic fifo_valid;
    logic fifo_in_ready;
    logic load_now;
    logic [adc14_pkg::CNT_W-1:0] step_gap;

    // Cycles per bit trial spread across the trial phase
    assign step_gap = adc14_pkg::CNT_W'(adc14_pkg::BIT_PHASE_CYC / WIDTH);
    // Resets high: a pin held low out of reset reads as a fall and starts
    assign trig_fall = trig_d_r & ~i_trigger;
    assign sar_start = (state_r == adc14_pkg::ST_RISE)
        && (cnt_r == '0);
    assign sar_step = (state_r == adc14_pkg::ST_TRIAL)
        && (cnt_r == '0);
    // Latches load once the strobe lead has run out
    assign load_now = (state_r == adc14_pkg::ST_STROBE)
        && (cnt_r == '0);
    // Move only with flag high and strobe low
    assign latch_load = load_now && eoc_r && !strobe_r;

    // ------------------------------------------------------------------
    // Counter helper
    // ------------------------------------------------------------------
    function automatic logic [adc14_pkg::CNT_W-1:0] dec_or(
        input logic [adc14_pkg::CNT_W-1:0] c,
        input logic [adc14_pkg::CNT_W-1:0] reload);
        dec_or = (c == '0) ? reload : c - 1'b1;
    endfunction : dec_or

    // ------------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------------
    sar_core #(
        .WIDTH(WIDTH)
    ) u_sar (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_ce(i_ce),
        .i_start(sar_start),
        .i_step(sar_step),
        .i_comp_hi(i_comp_hi),
        .o_trial(sar_trial),
        .o_done(sar_done)
    );

    // Full queue drops the push; pins still load
    sample_fifo #(
        .WIDTH(WIDTH),
        .DEPTH(DEPTH)
    ) u_fifo (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_ce(i_ce),
        .i_in_valid(load_now),
        .o_in_ready(fifo_in_ready),
        .i_in_data(sar_trial),
        .o_out_valid(fifo_valid),
        .i_out_ready(i_sample_ready),
        .o_out_data(fifo_out)
    );

    // ------------------------------------------------------------------
    // Trigger edge and low time
    // ------------------------------------------------------------------
    // Trigger history; starts high so a high pin gives no edge out of reset
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            trig_d_r <= 1'b1;
        end else if (i_ce) begin
            trig_d_r <= i_trigger;
        end
    end

    // Measures low time; flags a pulse shorter than the least low time
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            low_cnt_r <= '0;
            short_r <= 1'b0;
        end else if (i_ce) begin
            if (!i_trigger) begin
                if (low_cnt_r != '1) begin
                    low_cnt_r <= low_cnt_r + 1'b1;
                end
            end else begin
                low_cnt_r <= '0;
                if (!trig_d_r) begin
                    // Rising edge closes the low pulse
                    short_r <= (low_cnt_r <
                        adc14_pkg::CNT_W'(adc14_pkg::TRIG_LOW_MIN_CYC));
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // Next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            adc14_pkg::ST_IDLE: begin
                // A fall while busy is never seen here
                if (trig_fall) begin
                    state_nxt = adc14_pkg::ST_RISE;
                end
            end
            adc14_pkg::ST_RISE: begin
                if (cnt_r == '0) begin
                    state_nxt = adc14_pkg::ST_TRIAL;
                end
            end
            adc14_pkg::ST_TRIAL: begin
                if (sar_done) begin
                    state_nxt = adc14_pkg::ST_STROBE;
                end
            end
            adc14_pkg::ST_STROBE: begin
                if (cnt_r == '0) begin
                    state_nxt = adc14_pkg::ST_HOLD;
                end
            end
            adc14_pkg::ST_HOLD: begin
                if (cnt_r == '0) begin
                    state_nxt = adc14_pkg::ST_IDLE;
                end
            end
            default: begin
                state_nxt = adc14_pkg::ST_IDLE;
            end
        endcase
    end

    // State register
    // Busy falls drop out: only idle decodes them
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_r <= adc14_pkg::ST_IDLE;
        end else if (i_ce) begin
            state_r <= state_nxt;
        end
    end

    // Phase counter, reloaded on each state entry
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_r <= '0;
        end else if (i_ce) begin
            if (state_nxt != state_r) begin
                case (state_nxt)
                    adc14_pkg::ST_RISE: begin
                        cnt_r <= adc14_pkg::CNT_W'(
                            adc14_pkg::EOC_RISE_CYC - 1);
                    end
                    adc14_pkg::ST_STROBE: begin
                        cnt_r <= adc14_pkg::CNT_W'(
                            adc14_pkg::STROBE_LEAD_CYC - 1);
                    end
                    adc14_pkg::ST_HOLD: begin
                        cnt_r <= adc14_pkg::CNT_W'(
                            adc14_pkg::LOAD_LEAD_CYC - 1);
                    end
                    default: begin
                        cnt_r <= '0;
                    end
                endcase
            end else if (state_r == adc14_pkg::ST_TRIAL) begin
                cnt_r <= dec_or(cnt_r, step_gap - 1'b1);
            end else if (cnt_r != '0) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Flags
    // ------------------------------------------------------------------
    // Flag high from end of rise delay until hold ends
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            eoc_r <= 1'b0;
        end else if (i_ce) begin
            if (sar_start) begin
                eoc_r <= 1'b1;
            end else if (state_r == adc14_pkg::ST_HOLD
                && cnt_r == '0) begin
                eoc_r <= 1'b0;
            end
        end
    end

    // Strobe falls ahead of the load, rises after it; idle keeps level
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            strobe_r <= 1'b1;
        end else if (i_ce) begin
            if (state_r == adc14_pkg::ST_TRIAL && sar_done) begin
                strobe_r <= 1'b0;
            end else if (state_r == adc14_pkg::ST_HOLD) begin
                strobe_r <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Output latches
    // ------------------------------------------------------------------
    // Load only inside the flag-high, strobe-low window, else hold
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            latch_r <= adc14_pkg::RESULT_RST;
        end else if (i_ce) begin
            if (latch_load) begin
                latch_r <= sar_trial;
            end
        end
    end

    // Inverted MSB in its own flop
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            msb_n_r <= ~adc14_pkg::RESULT_RST[13];
        end else if (i_ce && latch_load) begin
            msb_n_r <= ~sar_trial[WIDTH-1];
        end
    end

    // Byte drive enables follow the active-low byte enables
    // One cycle late; hosts wait two edges
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            high_oe_r <= 1'b0;
            low_oe_r <= 1'b0;
        end else if (i_ce) begin
            high_oe_r <= ~i_high_en_n;
            low_oe_r <= ~i_low_en_n;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign o_eoc = eoc_r;
    assign o_data_update_strobe = strobe_r;
    assign o_result_msb_true = latch_r[WIDTH-1];
    assign o_result_msb_n = msb_n_r;
    assign o_high_bits = latch_r[WIDTH-2 -: 5];
    assign o_low_bits = latch_r[7:0];
    assign o_high_oe = high_oe_r;
    assign o_low_oe = low_oe_r;
    assign o_trig_short = short_r;
    assign o_sample = fifo_out;
    assign o_sample_valid = fifo_valid;

endmodule : adc14_readout

// *** tb/adc14_readout_asserts.sv ***
// Purpose: port checker for the converter readout block
// Assumes: one clock, asynchronous low active reset
// Notes: bound to every readout instance at the foot
`timescale 1ns/1ps
module adc14_readout_asserts #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 16
) (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic i_trigger,
    input wire logic i_high_en_n,
    input wire logic i_low_en_n,
    input wire logic i_comp_hi,
    input wire logic o_eoc,
    input wire logic o_data_update_strobe,
    input wire logic o_result_msb_n,
    input wire logic o_result_msb_true,
    input wire logic [4:0] o_high_bits,
    input wire logic [7:0] o_low_bits,
    input wire logic o_high_oe,
    input wire logic o_low_oe,
    input wire logic o_trig_short,
    input wire logic [WIDTH-1:0] o_sample,
    input wire logic o_sample_valid,
    input wire logic i_sample_ready
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rstn);
    logic [13:0] latch_w; // Result as the pins carry it
    logic [9:0] busy_r; // Cycles spent with the flag high
    assign latch_w = {o_result_msb_true, o_high_bits, o_low_bits};
    // Length of the conversion under way
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            busy_r <= 10'h000;
        end else begin
            busy_r <= o_eoc ? busy_r + 10'h001 : 10'h000;
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    AST_EOC_RISE: assert property ($fell(i_trigger) && !o_eoc
        && i_ce |-> ##[9:11] $rose(o_eoc)) else $error("Flag rise late");
    AST_LOAD_LEAD: assert property ($fell(o_data_update_strobe)
        |-> ##40 $fell(o_eoc)) else $error("Flag fall mistimed");
    AST_STROBE_LEAD: assert property (!$stable(latch_w)
        |-> !$past(o_data_update_strobe, 10)
        && $past(o_data_update_strobe, 11)) else $error("Strobe lead bad");
    AST_UPDATE_WINDOW: assert property (!$stable(latch_w)
        |-> $past(o_eoc) && !$past(o_data_update_strobe))
        else $error("Latch moved outside window");
    AST_IDLE_HOLD: assert property (!o_eoc && !$past(o_eoc)
        |-> $stable(latch_w)) else $error("Latch moved while idle");
    AST_CONV_BOUND: assert property (busy_r < 10'h2b2)
        else $error("Conversion too long");
    AST_MSB_PAIR: assert property (o_result_msb_n != o_result_msb_true)
        else $error("MSB pair not complementary");
    AST_HIGH_OE: assert property (o_high_oe == !$past(i_high_en_n))
        else $error("High byte drive wrong");
    AST_LOW_OE: assert property (o_low_oe == !$past(i_low_en_n))
        else $error("Low byte drive wrong");
    COV_DONE: cover property ($fell(o_eoc));
    COV_WIDE: cover property (o_high_oe && o_low_oe);
    COV_STALL: cover property (o_sample_valid && !i_sample_ready);
endmodule : adc14_readout_asserts

bind adc14_readout adc14_readout_asserts #(.WIDTH(WIDTH), .DEPTH(DEPTH))
    chk_u (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_ce(i_ce),
    .i_trigger(i_trigger), .i_high_en_n(i_high_en_n),
    .i_low_en_n(i_low_en_n), .i_comp_hi(i_comp_hi), .o_eoc(o_eoc),
    .o_data_update_strobe(o_data_update_strobe),
    .o_result_msb_n(o_result_msb_n), .o_result_msb_true(o_result_msb_true),
    .o_high_bits(o_high_bits), .o_low_bits(o_low_bits),
    .o_high_oe(o_high_oe), .o_low_oe(o_low_oe), .o_trig_short(o_trig_short),
    .o_sample(o_sample), .o_sample_valid(o_sample_valid),
    .i_sample_ready(i_sample_ready));

// *** tb/host_model.sv ***
// Purpose: host model, trigger pulses and byte reads
// Assumes: drives just after rising edges
// Notes: an undriven data line flips every cycle
`timescale 1ns/1ps
module host_model (
    input wire logic i_clk,
    input wire logic i_eoc,
    input wire logic i_stb,
    input wire logic i_mn,
    input wire logic i_mt,
    input wire logic [4:0] i_hb,
    input wire logic [7:0] i_lb,
    input wire logic i_hoe,
    input wire logic i_loe,
    output logic o_trig,
    output logic o_hen_n,
    output logic o_len_n
);
    logic [6:0] hi_last = 7'h00; // Previous high byte level
    logic [7:0] lo_last = 8'h00; // Previous low byte level
    logic [6:0] hi_bus; // High byte seen by the host
    logic [7:0] lo_bus; // Low byte seen by the host
    assign hi_bus = i_hoe ? {i_mn, i_mt, i_hb} : ~hi_last;
    assign lo_bus = i_loe ? i_lb : ~lo_last;
    // Floating lines never repeat stale data
    always @(posedge i_clk) begin
        hi_last <= hi_bus;
        lo_last <= lo_bus;
    end
    initial begin
        o_trig = 1'b1;
        o_hen_n = 1'b1;
        o_len_n = 1'b1;
    end
    // Low pulse of n_low cycles, then wait out the conversion
    task automatic convert(input int n_low, output int t_rise,
        output int t_end);
        t_rise = 0;
        t_end = 0;
        repeat (2) @(posedge i_clk);
        o_trig <= 1'b0;
        while (t_end < 2000 && (t_rise == 0 || i_eoc)) begin
            @(posedge i_clk);
            t_end++;
            if (t_end == n_low) o_trig <= 1'b1;
            if (t_rise == 0 && i_eoc) t_rise = t_end;
        end
    endtask : convert
    // Bare low pulse that waits for nothing
    task automatic pulse(input int n_low);
        @(posedge i_clk);
        o_trig <= 1'b0;
        repeat (n_low) @(posedge i_clk);
        o_trig <= 1'b1;
    endtask : pulse
    // Both bytes at once, or high then low byte alone
    task automatic read_word(input logic wide, input logic twos,
        output logic [13:0] w);
        logic [6:0] hi;
        while (i_eoc && !i_stb) @(posedge i_clk);
        @(posedge i_clk);
        o_hen_n <= 1'b0;
        o_len_n <= !wide;
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
        hi = hi_bus;
        w[7:0] = lo_bus;
        @(posedge i_clk);
        o_hen_n <= 1'b1;
        o_len_n <= wide;
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
        if (!wide) w[7:0] = lo_bus;
        @(posedge i_clk);
        o_len_n <= 1'b1;
        w[13] = twos ? hi[6] : hi[5];
        w[12:8] = hi[4:0];
    endtask : read_word
endmodule : host_model

// *** tb/tb_adc14_readout.sv ***
// Purpose: self-checking bench for the converter readout block
// Assumes: comparator held steady, results all ones or all zeros
// Notes: the host model makes trigger pulses and byte reads
`timescale 1ns/1ps
`define CHK(nm, ex, gt) \
    begin \
        tests_run++; \
        if ((gt) !== (ex)) begin \
            err_total++; \
            $display("Error %s expected %0h seen %0h", nm, ex, gt); \
        end \
    end
module tb_adc14_readout;
    localparam int LOW_OK = adc14_pkg::TRIG_LOW_MIN_CYC + 1; // Safe pulse
    localparam int CMAX = adc14_pkg::CONV_MAX_CYC; // Longest conversion
    logic i_ref_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic i_ce = 1'b1;
    logic i_comp_hi = 1'b0;
    logic i_sample_ready = 1'b1;
    logic i_trigger, i_high_en_n, i_low_en_n;
    logic o_eoc, o_data_update_strobe, o_result_msb_n, o_result_msb_true;
    logic [4:0] o_high_bits;
    logic [7:0] o_low_bits;
    logic o_high_oe, o_low_oe, o_trig_short, o_sample_valid;
    logic [13:0] o_sample;
    int err_total = 0;
    int tests_run = 0;
    int cyc = 0;
    always #5 i_ref_clk = ~i_ref_clk;
    adc14_readout dut_u (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_ce(i_ce),
        .i_trigger(i_trigger), .i_high_en_n(i_high_en_n),
        .i_low_en_n(i_low_en_n), .i_comp_hi(i_comp_hi), .o_eoc(o_eoc),
        .o_data_update_strobe(o_data_update_strobe),
        .o_result_msb_n(o_result_msb_n),
        .o_result_msb_true(o_result_msb_true), .o_high_bits(o_high_bits),
        .o_low_bits(o_low_bits), .o_high_oe(o_high_oe), .o_low_oe(o_low_oe),
        .o_trig_short(o_trig_short), .o_sample(o_sample),
        .o_sample_valid(o_sample_valid), .i_sample_ready(i_sample_ready));
    host_model host_u (.i_clk(i_ref_clk), .i_eoc(o_eoc),
        .i_stb(o_data_update_strobe), .i_mn(o_result_msb_n),
        .i_mt(o_result_msb_true), .i_hb(o_high_bits), .i_lb(o_low_bits),
        .i_hoe(o_high_oe), .i_loe(o_low_oe), .o_trig(i_trigger),
        .o_hen_n(i_high_en_n), .o_len_n(i_low_en_n));
    // Counts, verdict and end of run
    task automatic close_out();
        $display("Checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out
    // Full scale conversion, flag timing, wide read
    task automatic t_basic();
        int r, t;
        logic [13:0] w;
        i_comp_hi <= 1'b1;
        host_u.convert(LOW_OK, r, t);
        `CHK("flag rise", 1'b1, r inside {[9:12]});
        `CHK("conv time", 1'b1, t <= CMAX);
        `CHK("flag end", 1'b0, o_eoc);
        `CHK("short flag", 1'b0, o_trig_short);
        host_u.read_word(1'b1, 1'b0, w);
        `CHK("wide read", 14'h3fff, w);
    endtask : t_basic
    // Second fall while busy starts nothing; its short pulse is flagged
    task automatic t_busy();
        int r, t;
        i_comp_hi <= 1'b0;
        fork
            host_u.convert(LOW_OK, r, t);
            begin
                repeat (200) @(posedge i_ref_clk);
                host_u.pulse(5);
            end
        join
        `CHK("busy time", 1'b1, t <= CMAX);
        repeat (40) @(posedge i_ref_clk);
        `CHK("no restart", 1'b0, o_eoc);
        `CHK("short set", 1'b1, o_trig_short);
        `CHK("bytes float", 2'b00, {o_high_oe, o_low_oe});
    endtask : t_busy
    // All read modes and codings; old result held during next conversion
    task automatic t_reads();
        int r, t;
        logic [13:0] w, ex;
        for (int k = 0; k < 8; k++) begin
            if (k == 4) begin
                i_comp_hi <= 1'b1;
                fork
                    host_u.convert(LOW_OK, r, t);
                    begin
                        repeat (100) @(posedge i_ref_clk);
                        host_u.read_word(1'b1, 1'b0, w);
                        `CHK("held", 14'h0000, w);
                    end
                join
            end
            ex = {k[2] ^ k[0], {13{k[2]}}};
            host_u.read_word(k[1], k[0], w);
            `CHK("byte read", ex, w);
        end
        `CHK("short clear", 1'b0, o_trig_short);
    endtask : t_reads
    // Fill the queue past its depth while stalled, then drain it
    task automatic t_fifo();
        int r, t, n;
        i_sample_ready <= 1'b0;
        for (int k = 0; k <= adc14_pkg::FIFO_DEPTH; k++) begin
            i_comp_hi <= k[0];
            host_u.convert(LOW_OK, r, t);
        end
        n = 0;
        @(negedge i_ref_clk);
        while (o_sample_valid === 1'b1 && n < 40) begin
            `CHK("queue order", {14{n[0]}}, o_sample);
            @(posedge i_ref_clk);
            i_sample_ready <= 1'b1;
            @(posedge i_ref_clk);
            i_sample_ready <= 1'b0;
            @(negedge i_ref_clk);
            n++;
        end
        `CHK("queue count", adc14_pkg::FIFO_DEPTH, n);
    endtask : t_fifo
    // Main sequence
    initial begin
        repeat (4) @(posedge i_ref_clk);
        i_rstn <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
        t_basic();
        t_busy();
        t_reads();
        t_fifo();
        close_out();
    end
    // Hang guard
    always @(posedge i_ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_total++;
            close_out();
        end
    end
endmodule : tb_adc14_readout
